// *** logic/urs_request_regs.sv ***
// Request-data registers: endpoint1/2 halt status, device address, configuration value.
// Assumes requests arrive decoded from the SIE as one-cycle strobes on clock_i.
`default_nettype none
module urs_request_regs
  import urs_pkg::*;
(
  input wire logic clock_i,                 // 20 MHz clock
  input wire logic rst_i,                   // Async reset, active high
  input wire urs_cpu_type cpu_i,            // CPU bus access
  output logic [7:0] cpu_rdata_o,           // Read data
  input wire logic endpoint0_nak_all_i,     // Write enable control from endpoint0
  input wire logic ep1_usb_busy_i,          // USB access to endpoint1 in progress
  input wire logic ep2_usb_busy_i,          // USB access to endpoint2 in progress
  input wire logic ep1_error_i,             // Endpoint1 error pulse
  input wire logic ep2_error_i,             // Endpoint2 error pulse
  input wire urs_request_type req_i,        // Decoded standard requests
  output logic status_valid_o,              // Status byte for GET_STATUS is ready
  output logic [7:0] status_data_o,         // GET_STATUS answer byte
  output logic [7:0] get_config_data_o,     // GET_CONFIGURATION answer byte
  output logic [6:0] bus_address_o,         // Address the SIE matches
  output logic bulk_in_fifo_clear_o,        // Clear pulse for bulk_in_fifo
  output logic bulk_out_fifo_clear_o,       // Clear pulse for bulk_out_fifo
  output logic bulk_in_nak_release_clr_o,   // Clear pulse for bulk_in_nak_release
  output logic bulk_out_nak_release_clr_o,  // Clear pulse for bulk_out_nak_release
  output logic ep1_data_pid_init_o,         // Data PID reset for endpoint1
  output logic ep2_data_pid_init_o,         // Data PID reset for endpoint2
  output logic configured_flag_o            // configured_flag to mode_status
);

  logic [7:0] ep1_status_reg, ep1_status_next;
  logic [7:0] ep2_status_reg, ep2_status_next;
  logic [7:0] device_address_reg, device_address_next;
  logic [6:0] bus_address_reg, bus_address_next;
  logic [7:0] config_reg, config_next;
  logic configured_reg, configured_next;
  logic addr_pending_reg, addr_pending_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] status_reg, status_next;
  logic status_valid_reg, status_valid_next;
  logic stall1_pulse_reg, stall1_pulse_next;
  logic stall2_pulse_reg, stall2_pulse_next;
  logic pid1_reg, pid1_next;
  logic pid2_reg, pid2_next;
  logic clr1, clr2, set1, set2, fw_wr1, fw_wr2;

  // Halt bit update for one endpoint; hardware set wins over any clear
  function automatic logic [7:0] halt_update(input logic [7:0] cur, input logic fw_wr,
                                             input logic [7:0] wd, input logic set_h,
                                             input logic clr_h);
    logic [7:0] v;
    v = cur;
    if (fw_wr) begin
      v = {7'h00, wd[HALT_BIT_POS]};
    end
    if (clr_h) begin
      v[HALT_BIT_POS] = 1'b0;
    end
    if (set_h) begin
      v[HALT_BIT_POS] = 1'b1;
    end
    return v;
  endfunction : halt_update

  // Halt status registers
  always_comb begin
    fw_wr1 = cpu_i.wr && cpu_i.addr == ENDPOINT1_HALT_STATUS_OFS && endpoint0_nak_all_i
             && !ep1_usb_busy_i;
    fw_wr2 = cpu_i.wr && cpu_i.addr == ENDPOINT2_HALT_STATUS_OFS && endpoint0_nak_all_i
             && !ep2_usb_busy_i;
    set1 = ep1_error_i || (req_i.set_feature_ep && req_i.endpoint == ENDPOINT1_NUM);
    set2 = ep2_error_i || (req_i.set_feature_ep && req_i.endpoint == ENDPOINT2_NUM);
    clr1 = (req_i.clear_feature_ep && req_i.endpoint == ENDPOINT1_NUM) || req_i.set_configuration
           || req_i.set_interface_ep1;
    clr2 = (req_i.clear_feature_ep && req_i.endpoint == ENDPOINT2_NUM) || req_i.set_configuration
           || req_i.set_interface_ep2;
    ep1_status_next = halt_update(ep1_status_reg, fw_wr1, cpu_i.wdata, set1, clr1);
    ep2_status_next = halt_update(ep2_status_reg, fw_wr2, cpu_i.wdata, set2, clr2);
    // Stall entry is the rising edge of the halt bit
    stall1_pulse_next = ep1_status_next[HALT_BIT_POS] && !ep1_status_reg[HALT_BIT_POS];
    stall2_pulse_next = ep2_status_next[HALT_BIT_POS] && !ep2_status_reg[HALT_BIT_POS];
    pid1_next = clr1;
    pid2_next = clr2;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ep1_status_reg <= HALT_STATUS_RST;
      ep2_status_reg <= HALT_STATUS_RST;
      stall1_pulse_reg <= 1'b0;
      stall2_pulse_reg <= 1'b0;
      pid1_reg <= 1'b0;
      pid2_reg <= 1'b0;
    end else begin
      ep1_status_reg <= ep1_status_next;
      ep2_status_reg <= ep2_status_next;
      stall1_pulse_reg <= stall1_pulse_next;
      stall2_pulse_reg <= stall2_pulse_next;
      pid1_reg <= pid1_next;
      pid2_reg <= pid2_next;
    end
  end

  // Address and configuration; firmware writes to them are dropped
  always_comb begin
    device_address_next = device_address_reg;
    addr_pending_next = addr_pending_reg;
    bus_address_next = bus_address_reg;
    config_next = config_reg;
    configured_next = configured_reg;
    if (req_i.set_address) begin
      device_address_next = {1'b0, req_i.address};
      addr_pending_next = 1'b1;
    end else if (addr_pending_reg && req_i.status_success) begin
      bus_address_next = device_address_reg[ADDRESS_MSB:0];
      addr_pending_next = 1'b0;
    end
    if (req_i.set_configuration) begin
      config_next = {6'h00, req_i.config_bits};
    end
    // Flag follows the register at once, not the status stage
    if (config_reg == CONFIG_ZERO && config_next != CONFIG_ZERO) begin
      configured_next = 1'b1;
    end else if (config_next == CONFIG_ZERO) begin
      configured_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      device_address_reg <= DEVICE_ADDRESS_RST;
      addr_pending_reg <= 1'b0;
      bus_address_reg <= 7'h00;
      config_reg <= CONFIGURATION_VALUE_RST;
      configured_reg <= 1'b0;
    end else begin
      device_address_reg <= device_address_next;
      addr_pending_reg <= addr_pending_next;
      bus_address_reg <= bus_address_next;
      config_reg <= config_next;
      configured_reg <= configured_next;
    end
  end

  // CPU read mux and GET_STATUS answer
  always_comb begin
    if (cpu_i.addr == DEVICE_ADDRESS_OFS) begin
      rdata_next = device_address_reg;
    end else if (cpu_i.addr == CONFIGURATION_VALUE_OFS) begin
      rdata_next = config_reg;
    end else if (cpu_i.addr == ENDPOINT1_HALT_STATUS_OFS) begin
      rdata_next = ep1_status_reg;
    end else if (cpu_i.addr == ENDPOINT2_HALT_STATUS_OFS) begin
      rdata_next = ep2_status_reg;
    end else begin
      rdata_next = UNMAPPED_READ;
    end
    if (!cpu_i.rd) begin
      rdata_next = rdata_reg;
    end
    status_valid_next = req_i.get_status_ep
                        && (req_i.endpoint == ENDPOINT1_NUM || req_i.endpoint == ENDPOINT2_NUM);
    status_next = status_reg;
    if (status_valid_next) begin
      status_next = (req_i.endpoint == ENDPOINT1_NUM) ? ep1_status_reg : ep2_status_reg;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
      status_reg <= 8'h00;
      status_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      status_reg <= status_next;
      status_valid_reg <= status_valid_next;
    end
  end

  assign cpu_rdata_o = rdata_reg;
  assign status_valid_o = status_valid_reg;
  assign status_data_o = status_reg;
  assign get_config_data_o = config_reg;
  assign bus_address_o = bus_address_reg;
  assign bulk_in_fifo_clear_o = stall1_pulse_reg;
  assign bulk_in_nak_release_clr_o = stall1_pulse_reg;
  assign bulk_out_fifo_clear_o = stall2_pulse_reg;
  assign bulk_out_nak_release_clr_o = stall2_pulse_reg;
  assign ep1_data_pid_init_o = pid1_reg;
  assign ep2_data_pid_init_o = pid2_reg;
  assign configured_flag_o = configured_reg;

  // Checks
  write_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (cpu_i.wr && cpu_i.addr == ENDPOINT1_HALT_STATUS_OFS && !endpoint0_nak_all_i && !ep1_error_i
     && !req_i.set_feature_ep && !req_i.set_configuration && !req_i.clear_feature_ep && !req_i.set_interface_ep1)
    |=> $stable(ep1_status_reg)) else $error("ep1 write taken without nak_all");
  busy_one_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ep1_usb_busy_i && !ep1_error_i && !req_i.set_feature_ep && !req_i.set_configuration
     && !req_i.clear_feature_ep && !req_i.set_interface_ep1) |=> $stable(ep1_status_reg))
    else $error("ep1 changed during USB access");
  busy_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ep2_usb_busy_i && !ep2_error_i && !req_i.set_feature_ep && !req_i.set_configuration
     && !req_i.clear_feature_ep && !req_i.set_interface_ep2) |=> $stable(ep2_status_reg))
    else $error("ep2 changed during USB access");
  error_one_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ep1_error_i |=> ep1_status_reg[HALT_BIT_POS]) else $error("ep1 error did not halt");
  error_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ep2_error_i |=> ep2_status_reg[HALT_BIT_POS]) else $error("ep2 error did not halt");
  stall_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(ep1_status_reg[HALT_BIT_POS]) |-> bulk_in_fifo_clear_o && bulk_in_nak_release_clr_o)
    else $error("ep1 stall did not clear bulk in");
  cfg_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (req_i.set_configuration && !ep1_error_i) |=> !ep1_status_reg[HALT_BIT_POS] ##0 ep1_data_pid_init_o)
    else $error("set configuration did not clear halt");
  addr_defer_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !req_i.status_success |=> $stable(bus_address_o)) else $error("address used before handshake");
  configured_flag_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (config_reg == CONFIG_ZERO && req_i.set_configuration && req_i.config_bits != 2'h0)
    |=> configured_flag_o && config_reg != CONFIG_ZERO) else $error("configured flag late");

  // Checks below leave out same-cycle set requests, because set wins by design
  // and a clear would otherwise look lost. They only sample on the rising clock edge,
  // so a glitch on the request strobes between edges cannot trip them.

  // Second halt register obeys the same write gate
  write_gate_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (cpu_i.wr && cpu_i.addr == ENDPOINT2_HALT_STATUS_OFS && !endpoint0_nak_all_i && !ep2_error_i
     && !req_i.set_feature_ep && !req_i.set_configuration && !req_i.clear_feature_ep && !req_i.set_interface_ep2)
    |=> $stable(ep2_status_reg))
    else $error("ep2 write taken without nak_all");

  // Only the halt bit is storage; the upper bits always read 0
  halt_upper_a: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ep1_status_reg[7:1] == 7'h00 && ep2_status_reg[7:1] == 7'h00)
    else $error("halt upper bits set");

  // Endpoint2 stall entry clears the bulk out side
  stall_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(ep2_status_reg[HALT_BIT_POS])
    |-> bulk_out_fifo_clear_o && bulk_out_nak_release_clr_o)
    else $error("ep2 stall did not clear bulk out");

  // Bulk in clear pulses only on stall entry, never spuriously
  stall_only_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bulk_in_fifo_clear_o || bulk_in_nak_release_clr_o
    |-> $rose(ep1_status_reg[HALT_BIT_POS]))
    else $error("bulk in cleared without stall");

  // Bulk out clear pulses only on stall entry, never spuriously
  stall_only_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bulk_out_fifo_clear_o || bulk_out_nak_release_clr_o
    |-> $rose(ep2_status_reg[HALT_BIT_POS]))
    else $error("bulk out cleared without stall");

  // GET_STATUS to endpoint1 answers with the register as it stood
  status_one_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.get_status_ep && req_i.endpoint == ENDPOINT1_NUM
    |=> status_valid_o && status_data_o == $past(ep1_status_reg))
    else $error("ep1 status answer wrong");

  // GET_STATUS to endpoint2 answers with the register as it stood
  status_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.get_status_ep && req_i.endpoint == ENDPOINT2_NUM
    |=> status_valid_o && status_data_o == $past(ep2_status_reg))
    else $error("ep2 status answer wrong");

  // No answer strobe without a request
  status_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !req_i.get_status_ep
    |=> !status_valid_o)
    else $error("status answer without request");

  // SET_FEATURE halts endpoint1
  feature_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.set_feature_ep && req_i.endpoint == ENDPOINT1_NUM
    |=> ep1_status_reg[HALT_BIT_POS])
    else $error("ep1 set feature lost");

  // SET_FEATURE halts endpoint2
  feature_set_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.set_feature_ep && req_i.endpoint == ENDPOINT2_NUM
    |=> ep2_status_reg[HALT_BIT_POS])
    else $error("ep2 set feature lost");

  // CLEAR_FEATURE releases endpoint1 and restarts its data PID
  feature_clr_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.clear_feature_ep && req_i.endpoint == ENDPOINT1_NUM && !ep1_error_i && !req_i.set_feature_ep
    |=> !ep1_status_reg[HALT_BIT_POS] && ep1_data_pid_init_o)
    else $error("ep1 clear feature lost");

  // SET_INTERFACE releases endpoint2 and restarts its data PID
  intf_clr_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.set_interface_ep2 && !ep2_error_i && !req_i.set_feature_ep
    |=> !ep2_status_reg[HALT_BIT_POS] && ep2_data_pid_init_o)
    else $error("ep2 set interface did not clear halt");

  // SET_ADDRESS value lands in the address bits, top bit stays 0
  addr_store_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.set_address
    |=> device_address_reg == {1'b0, $past(req_i.address)})
    else $error("device address not stored");

  // Stored address goes live on the status-stage handshake
  addr_apply_a: assert property (@(posedge clock_i) disable iff (rst_i)
    addr_pending_reg && req_i.status_success && !req_i.set_address
    |=> bus_address_o == $past(device_address_reg[ADDRESS_MSB:0]))
    else $error("address not applied after handshake");

  // Address register is read-only: only SET_ADDRESS moves it
  ro_address_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !req_i.set_address
    |=> $stable(device_address_reg))
    else $error("device address changed without request");

  // SET_CONFIGURATION value lands in the configuration bits
  cfg_store_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.set_configuration
    |=> config_reg == {6'h00, $past(req_i.config_bits)} && get_config_data_o == config_reg)
    else $error("configuration not stored");

  // Configuration register is read-only: only SET_CONFIGURATION moves it
  cfg_ro_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !req_i.set_configuration
    |=> $stable(config_reg))
    else $error("configuration changed without request");

  // Flag never claims configured while the value is zero
  configured_flag_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    config_reg == CONFIG_ZERO
    |-> !configured_flag_o)
    else $error("configured flag with zero value");

  // Read data holds between reads so readback is stable
  rdata_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !cpu_i.rd
    |=> $stable(cpu_rdata_o))
    else $error("read data changed without read");
endmodule : urs_request_regs
`default_nettype wire

// *** shared/urs_pkg.sv ***
// Package for the USB request-data register block: offsets, field positions,
// reset values and the request event carrier.
// Assumes an 8-bit CPU bus with 16-bit addresses and an SIE that decodes requests.
`default_nettype none
package urs_pkg;
  localparam logic [15:0] DEVICE_ADDRESS_OFS = 16'hFF90;
  localparam logic [15:0] CONFIGURATION_VALUE_OFS = 16'hFF91;
  localparam logic [15:0] ENDPOINT1_HALT_STATUS_OFS = 16'hFF9D;
  localparam logic [15:0] ENDPOINT2_HALT_STATUS_OFS = 16'hFF9E;
  localparam int HALT_BIT_POS = 0;
  localparam int ADDRESS_MSB = 6;
  localparam int CONFIG_MSB = 1;
  localparam logic [7:0] DEVICE_ADDRESS_RST = 8'h00;
  localparam logic [7:0] CONFIGURATION_VALUE_RST = 8'h00;
  localparam logic [7:0] HALT_STATUS_RST = 8'h00;
  localparam logic [7:0] CONFIG_ZERO = 8'h00;
  localparam logic [1:0] ENDPOINT1_NUM = 2'h1;
  localparam logic [1:0] ENDPOINT2_NUM = 2'h2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Standard requests as decoded by the SIE, one-cycle strobes
  typedef struct packed {
    logic set_feature_ep;    // SET_FEATURE ENDPOINT_HALT
    logic clear_feature_ep;  // CLEAR_FEATURE ENDPOINT_HALT
    logic get_status_ep;     // GET_STATUS endpoint
    logic [1:0] endpoint;    // Target endpoint number
    logic set_address;       // SET_ADDRESS decoded
    logic [6:0] address;     // wValue of SET_ADDRESS
    logic status_success;    // Successful handshake in status stage
    logic set_configuration; // SET_CONFIGURATION received
    logic [1:0] config_bits; // wValue of SET_CONFIGURATION
    logic set_interface_ep1; // SET_INTERFACE for owner of endpoint1
    logic set_interface_ep2; // SET_INTERFACE for owner of endpoint2
  } urs_request_type;

  // CPU bus access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } urs_cpu_type;
endpackage : urs_pkg
`default_nettype wire

// *** verification/urs_sie_model.sv ***
// Behavioural stand-in for the serial interface engine side of the request registers.
// Assumes the testbench calls its tasks; send and error change outputs on the falling clock edge, busy changes its level at once.
`default_nettype none
module urs_sie_model
  import urs_pkg::*;
(
  input wire logic clock_i,         // Same clock as the block
  output urs_request_type req_o,    // Decoded request strobes
  output logic ep1_busy_o,          // USB access to endpoint1
  output logic ep2_busy_o,          // USB access to endpoint2
  output logic ep1_error_o,         // Endpoint1 error pulse
  output logic ep2_error_o          // Endpoint2 error pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // Outputs start at zero; after a strobe the idle qualifiers carry inverted junk so that a design reading them outside a strobe is caught
  initial begin
    req_o = '0;
    ep1_busy_o = 1'b0;
    ep2_busy_o = 1'b0;
    ep1_error_o = 1'b0;
    ep2_error_o = 1'b0;
  end

  // One request strobe for one cycle: 0 set_feature, 1 clear_feature, 2 get_status,
  // 3 set_address, 4 status_success, 5 set_configuration, 6/7 set_interface ep1/ep2
  task automatic send(input int kind, input logic [1:0] ep, input logic [6:0] val);
    urs_request_type r;
    r = '0;
    r.endpoint = ep;
    r.address = val;
    r.config_bits = val[1:0];
    case (kind)
      0: r.set_feature_ep = 1'b1;
      1: r.clear_feature_ep = 1'b1;
      2: r.get_status_ep = 1'b1;
      3: r.set_address = 1'b1;
      4: r.status_success = 1'b1;
      5: r.set_configuration = 1'b1;
      6: r.set_interface_ep1 = 1'b1;
      default: r.set_interface_ep2 = 1'b1;
    endcase
    @(negedge clock_i);
    req_o = r;
    @(negedge clock_i);
    r = ~r;
    r.set_feature_ep = 1'b0;
    r.clear_feature_ep = 1'b0;
    r.get_status_ep = 1'b0;
    r.set_address = 1'b0;
    r.status_success = 1'b0;
    r.set_configuration = 1'b0;
    r.set_interface_ep1 = 1'b0;
    r.set_interface_ep2 = 1'b0;
    req_o = r;
  endtask : send

  // Level of the USB-side access flag for one endpoint
  task automatic busy(input int ep, input logic on);
    if (ep == 1) ep1_busy_o = on; else ep2_busy_o = on;
  endtask : busy

  // Error pulse of one cycle on the chosen endpoint
  task automatic error(input int ep);
    @(negedge clock_i);
    if (ep == 1) ep1_error_o = 1'b1; else ep2_error_o = 1'b1;
    @(negedge clock_i);
    ep1_error_o = 1'b0;
    ep2_error_o = 1'b0;
  endtask : error
endmodule : urs_sie_model
`default_nettype wire

// *** verification/usb_request_status_registers_test.sv ***
// Self-checking bench for the request-data registers: firmware bus tasks plus SIE model.
// Assumes a 20 MHz clock and the hand-over timing of one-cycle strobes and registered outputs.
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module usb_request_status_registers_test
  import urs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, rst_i = 1'b1, nak_all = 1'b0;
  urs_cpu_type cpu = '0;
  urs_request_type req;
  logic b1, b2, e1, e2, sv, bif, bof, bin, bon, p1, p2, cfg;
  logic [7:0] rdata, sdata, gcfg;
  logic [6:0] bus_adr, seen = '0;
  int err_count = 0, n_compared = 0;

  initial forever #25 clock_i = ~clock_i;

  urs_request_regs i_dut (.clock_i(clock_i), .rst_i(rst_i), .cpu_i(cpu), .cpu_rdata_o(rdata),
    .endpoint0_nak_all_i(nak_all), .ep1_usb_busy_i(b1), .ep2_usb_busy_i(b2), .ep1_error_i(e1),
    .ep2_error_i(e2), .req_i(req), .status_valid_o(sv), .status_data_o(sdata), .get_config_data_o(gcfg),
    .bus_address_o(bus_adr), .bulk_in_fifo_clear_o(bif), .bulk_out_fifo_clear_o(bof),
    .bulk_in_nak_release_clr_o(bin), .bulk_out_nak_release_clr_o(bon), .ep1_data_pid_init_o(p1),
    .ep2_data_pid_init_o(p2), .configured_flag_o(cfg));
  urs_sie_model i_sie (.clock_i(clock_i), .req_o(req), .ep1_busy_o(b1), .ep2_busy_o(b2),
    .ep1_error_o(e1), .ep2_error_o(e2));

  // Sticky record of one-cycle pulses, sampled where they are settled
  always @(negedge clock_i) seen <= seen | {sv, bif, bof, bin, bon, p1, p2};

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  // Cleared on the rising edge so it never races the sampling process
  task automatic clr();
    @(posedge clock_i);
    seen = '0;
  endtask : clr
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    cpu = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock_i);
    cpu.wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    cpu = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    cpu.rd = 1'b0;
    @(negedge clock_i);
    `CHK(rdata, exp)
  endtask : rd_chk
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // Hang guard: running out counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    finish_test();
  end

  initial begin
    cyc(12);
    rst_i = 1'b0;
    cyc(2);
    rd_chk(DEVICE_ADDRESS_OFS, 8'h00);
    rd_chk(CONFIGURATION_VALUE_OFS, 8'h00);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h00);
    rd_chk(ENDPOINT2_HALT_STATUS_OFS, 8'h00);
    rd_chk(16'hFF80, 8'h00);
    // Halt writes refused while endpoint0 is not NAKing everything
    wr(ENDPOINT1_HALT_STATUS_OFS, 8'h01);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h00);
    nak_all = 1'b1;
    clr();
    wr(ENDPOINT1_HALT_STATUS_OFS, 8'hFF);
    cyc(3);
    `CHK(seen, 7'b0101000)
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h01);
    // Writes during a USB-side access are dropped
    i_sie.busy(1, 1'b1);
    wr(ENDPOINT1_HALT_STATUS_OFS, 8'h00);
    i_sie.busy(1, 1'b0);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h01);
    i_sie.busy(2, 1'b1);
    wr(ENDPOINT2_HALT_STATUS_OFS, 8'h01);
    i_sie.busy(2, 1'b0);
    rd_chk(ENDPOINT2_HALT_STATUS_OFS, 8'h00);
    clr();
    wr(ENDPOINT2_HALT_STATUS_OFS, 8'h01);
    cyc(3);
    `CHK(seen, 7'b0010100)
    // Host clears, then errors set the halt bits again
    clr();
    i_sie.send(1, ENDPOINT1_NUM, 7'h00);
    cyc(3);
    `CHK(seen, 7'b0000010)
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h00);
    i_sie.error(1);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h01);
    clr();
    i_sie.send(1, ENDPOINT2_NUM, 7'h00);
    cyc(1);
    `CHK(seen[0], 1'b1)
    rd_chk(ENDPOINT2_HALT_STATUS_OFS, 8'h00);
    i_sie.error(2);
    rd_chk(ENDPOINT2_HALT_STATUS_OFS, 8'h01);
    clr();
    i_sie.send(2, ENDPOINT1_NUM, 7'h00);
    cyc(3);
    `CHK(seen[6], 1'b1)
    `CHK(sdata, 8'h01)
    i_sie.send(2, ENDPOINT2_NUM, 7'h00);
    cyc(1);
    `CHK(sdata, 8'h01)
    // Configuration clears both halts and raises the configured flag at once
    i_sie.send(5, 2'h0, 7'h02);
    cyc(1);
    `CHK(cfg, 1'b1)
    `CHK(gcfg, 8'h02)
    rd_chk(CONFIGURATION_VALUE_OFS, 8'h02);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h00);
    rd_chk(ENDPOINT2_HALT_STATUS_OFS, 8'h00);
    i_sie.send(0, ENDPOINT1_NUM, 7'h00);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h01);
    i_sie.send(6, 2'h0, 7'h00);
    rd_chk(ENDPOINT1_HALT_STATUS_OFS, 8'h00);
    // New address is stored at once but used only after the status handshake
    i_sie.send(3, 2'h0, 7'h05);
    rd_chk(DEVICE_ADDRESS_OFS, 8'h05);
    `CHK(bus_adr, 7'h00)
    i_sie.send(4, 2'h0, 7'h00);
    cyc(2);
    `CHK(bus_adr, 7'h05)
    finish_test();
  end
endmodule : usb_request_status_registers_test
`default_nettype wire
